// >>> port0_pkg.sv
package port0_pkg;
   localparam int PORT_WIDTH = 8;
   localparam int HALF_WIDTH = 4;
   // Direction: 1 = input, 0 = output
   localparam logic [7:0] DIR_RESET     = 8'hFF;
   localparam logic [7:0] LATCH_RESET   = 8'h00;
   localparam logic [3:0] BUF_RESET     = 4'h0;
   localparam logic       RT_EN_RESET   = 1'b0;
   localparam logic       PULLUP_RESET  = 1'b0;
   localparam int LOW_LSB  = 0;
   localparam int HIGH_LSB = 4;
   typedef enum logic [1:0] {
      RT_NONE = 2'b00,
      RT_LOW  = 2'b01,
      RT_HIGH = 2'b10,
      RT_BOTH = 2'b11
   } rt_mode_t;
endpackage

// >>> port0_latch.sv
`timescale 1ns/100ps
module port0_latch (
   // Clock and reset
   input  wire logic                             mclk,
   input  wire logic                             sys_rst,
   // Write request
   input  wire logic                             wr,
   input  wire logic [port0_pkg::PORT_WIDTH-1:0] wr_data,
   // Bits held against writes
   input  wire logic [port0_pkg::PORT_WIDTH-1:0] protect,
   // Latch contents
   output logic      [port0_pkg::PORT_WIDTH-1:0] latch
);
   import port0_pkg::*;

   wire [PORT_WIDTH-1:0] next_latch;

   // Protected bits keep their value; others take the write
   assign next_latch = wr ? ((latch & protect) | (wr_data & ~protect))
                          : latch;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         latch <= LATCH_RESET;
      end else begin
         latch <= next_latch;
      end
   end
endmodule

// >>> port0_gpio_realtime_output.sv
`timescale 1ns/100ps
module port0_gpio_realtime_output (
   // Clock and reset
   input  wire logic                             mclk,
   input  wire logic                             sys_rst,
   // Output latch access
   input  wire logic                             latch_wr,
   input  wire logic [port0_pkg::PORT_WIDTH-1:0] latch_wr_data,
   input  wire logic                             latch_rd,
   output logic      [port0_pkg::PORT_WIDTH-1:0] port_rd_data,
   // Direction register
   input  wire logic                             dir_wr,
   input  wire logic [port0_pkg::PORT_WIDTH-1:0] dir_wr_data,
   output logic      [port0_pkg::PORT_WIDTH-1:0] port_direction_reg,
   // Realtime output control
   input  wire logic                             rtctl_wr,
   input  wire logic                             rtctl_low_data,
   input  wire logic                             rtctl_high_data,
   output logic                                  realtime_low_enable,
   output logic                                  realtime_high_enable,
   // Realtime buffers
   input  wire logic                             rtbuf_low_wr,
   input  wire logic [port0_pkg::HALF_WIDTH-1:0] rtbuf_low_data,
   input  wire logic                             rtbuf_high_wr,
   input  wire logic [port0_pkg::HALF_WIDTH-1:0] rtbuf_high_data,
   output logic      [port0_pkg::HALF_WIDTH-1:0] realtime_buffer_low,
   output logic      [port0_pkg::HALF_WIDTH-1:0] realtime_buffer_high,
   // Pull-up control
   input  wire logic                             pullup_wr,
   input  wire logic                             pullup_data,
   output logic                                  port_pullup_enable,
   // Port pins
   input  wire logic [port0_pkg::PORT_WIDTH-1:0] port_pins_in,
   output logic      [port0_pkg::PORT_WIDTH-1:0] port_pins_out,
   output logic      [port0_pkg::PORT_WIDTH-1:0] port_pins_oe,
   output logic      [port0_pkg::PORT_WIDTH-1:0] port_pullup_on
);
   import port0_pkg::*;

   // Widen a half enable over its nibble
   function automatic logic [PORT_WIDTH-1:0] rt_mask(input rt_mode_t m);
      unique case (m)
         RT_NONE: rt_mask = {PORT_WIDTH{1'b0}};
         RT_LOW:  rt_mask = {{HALF_WIDTH{1'b0}}, {HALF_WIDTH{1'b1}}};
         RT_HIGH: rt_mask = {{HALF_WIDTH{1'b1}}, {HALF_WIDTH{1'b0}}};
         RT_BOTH: rt_mask = {PORT_WIDTH{1'b1}};
      endcase
   endfunction

   // Bits set in keep take old_v, the rest take new_v
   function automatic logic [PORT_WIDTH-1:0] keep_bits(
      input logic [PORT_WIDTH-1:0] old_v,
      input logic [PORT_WIDTH-1:0] new_v,
      input logic [PORT_WIDTH-1:0] keep
   );
      keep_bits = (old_v & keep) | (new_v & ~keep);
   endfunction

   // Internal nets
   wire  [PORT_WIDTH-1:0] latch;
   wire  [PORT_WIDTH-1:0] rt_bits;
   wire  [PORT_WIDTH-1:0] in_bits;
   wire  [PORT_WIDTH-1:0] next_rt_bits;
   wire  [PORT_WIDTH-1:0] next_dir;
   wire  [PORT_WIDTH-1:0] next_oe;
   wire  [PORT_WIDTH-1:0] next_out;
   wire  [PORT_WIDTH-1:0] next_pullup;
   wire  [PORT_WIDTH-1:0] next_rd;
   wire  [PORT_WIDTH-1:0] next_rd_data;
   wire  [PORT_WIDTH-1:0] next_latch_view;
   wire                   next_rt_low;
   wire                   next_rt_high;
   wire  [HALF_WIDTH-1:0] next_buf_low;
   wire  [HALF_WIDTH-1:0] next_buf_high;
   wire                   next_pu_en;
   rt_mode_t              rt_mode;
   rt_mode_t              next_rt_mode;

   // Current realtime mode and the pins it owns
   assign rt_mode = rt_mode_t'({realtime_high_enable, realtime_low_enable});
   assign rt_bits = rt_mask(rt_mode);
   assign in_bits = port_direction_reg & ~rt_bits;

   // Latch with realtime bits write-protected
   port0_latch port0_latch_inst (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .wr      (latch_wr),
      .wr_data (latch_wr_data),
      .protect (rt_bits),
      .latch   (latch)
   );

   // Register next values
   assign next_dir      = dir_wr ? dir_wr_data : port_direction_reg;
   assign next_rt_low   = rtctl_wr ? rtctl_low_data : realtime_low_enable;
   assign next_rt_high  = rtctl_wr ? rtctl_high_data : realtime_high_enable;
   assign next_buf_low  = rtbuf_low_wr ? rtbuf_low_data : realtime_buffer_low;
   assign next_buf_high = rtbuf_high_wr ? rtbuf_high_data
                                        : realtime_buffer_high;
   assign next_pu_en    = pullup_wr ? pullup_data : port_pullup_enable;

   // Next mode and the pins it will own
   assign next_rt_mode = rt_mode_t'({next_rt_high, next_rt_low});
   assign next_rt_bits = rt_mask(next_rt_mode);

   // Realtime bits drive their buffer and always have their driver on
   assign next_oe  = ~next_dir | next_rt_bits;
   assign next_latch_view = latch_wr ?
                            keep_bits(latch, latch_wr_data, rt_bits) : latch;
   assign next_out = keep_bits({next_buf_high, next_buf_low},
                               next_latch_view, next_rt_bits);
   assign next_pullup = {PORT_WIDTH{next_pu_en}} & next_dir &
                        ~next_rt_bits;

   // Inputs read the pin, outputs and realtime bits read the latch
   assign next_rd = keep_bits(port_pins_in, latch, in_bits);
   // Read capture holds until the next read
   assign next_rd_data = latch_rd ? next_rd : port_rd_data;

   // Direction register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         port_direction_reg <= DIR_RESET;
      end else begin
         port_direction_reg <= next_dir;
      end
   end

   // Low half realtime enable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         realtime_low_enable <= RT_EN_RESET;
      end else begin
         realtime_low_enable <= next_rt_low;
      end
   end

   // High half realtime enable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         realtime_high_enable <= RT_EN_RESET;
      end else begin
         realtime_high_enable <= next_rt_high;
      end
   end

   // Low realtime buffer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         realtime_buffer_low <= BUF_RESET;
      end else begin
         realtime_buffer_low <= next_buf_low;
      end
   end

   // High realtime buffer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         realtime_buffer_high <= BUF_RESET;
      end else begin
         realtime_buffer_high <= next_buf_high;
      end
   end

   // Pull-up enable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         port_pullup_enable <= PULLUP_RESET;
      end else begin
         port_pullup_enable <= next_pu_en;
      end
   end

   // Pin drivers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         port_pins_oe <= {PORT_WIDTH{1'b0}};
      end else begin
         port_pins_oe <= next_oe;
      end
   end

   // Pin drive values
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         port_pins_out <= LATCH_RESET;
      end else begin
         port_pins_out <= next_out;
      end
   end

   // Pull-up connections
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         port_pullup_on <= {PORT_WIDTH{1'b0}};
      end else begin
         port_pullup_on <= next_pullup;
      end
   end

   // Read data capture
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         port_rd_data <= LATCH_RESET;
      end else begin
         port_rd_data <= next_rd_data;
      end
   end
endmodule

// >>> port0_gpio_realtime_output_sva.sv
`timescale 1ns/100ps
module port0_gpio_realtime_output_chk (
   input wire logic       mclk, sys_rst, latch_rd, dir_wr, rtctl_wr,
   input wire logic       rtctl_low_data, rtctl_high_data, pullup_wr,
   input wire logic       realtime_low_enable, realtime_high_enable,
   input wire logic       pullup_data, port_pullup_enable,
   input wire logic [7:0] port_rd_data, dir_wr_data, port_direction_reg,
   input wire logic [7:0] port_pins_in, port_pins_out, port_pins_oe,
   input wire logic [7:0] port_pullup_on,
   input wire logic [3:0] realtime_buffer_low, realtime_buffer_high
);
   wire logic [7:0] rtm = {{4{realtime_high_enable}},
                           {4{realtime_low_enable}}};
   wire logic [7:0] inpin = port_direction_reg & ~rtm;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   AST_RESET: assert property (disable iff (1'b0) sys_rst |=>
      port_pins_oe == 8'h00 && port_direction_reg == 8'hFF) else $error("rst");
   AST_OE: assert property (port_pins_oe == (~port_direction_reg | rtm))
      else $error("oe");
   AST_PULLUP: assert property (
      port_pullup_on == ({8{port_pullup_enable}} & inpin)) else $error("pu");
   AST_RT_LOW: assert property (realtime_low_enable |->
      port_pins_out[3:0] == realtime_buffer_low) else $error("rtl");
   AST_RT_HIGH: assert property (realtime_high_enable |->
      port_pins_out[7:4] == realtime_buffer_high) else $error("rth");
   AST_DIR: assert property (dir_wr |=>
      port_direction_reg == $past(dir_wr_data)) else $error("dir");
   AST_CTRL: assert property (rtctl_wr |=>
      realtime_low_enable == $past(rtctl_low_data)) else $error("ctl");
   AST_PU_WR: assert property (pullup_wr |=>
      port_pullup_enable == $past(pullup_data)) else $error("puw");
   AST_READ: assert property (latch_rd |=> ((port_rd_data
      ^ $past(port_pins_in)) & $past(inpin)) == 8'h00) else $error("rd");
   cover property (rtm == 8'hFF);
   cover property (latch_rd && inpin != 8'h00);
   cover property (port_pullup_on != 8'h00);
endmodule
bind port0_gpio_realtime_output port0_gpio_realtime_output_chk
   port0_gpio_realtime_output_chk_inst (.*);

// >>> pin_load.sv
`timescale 1ns/100ps
module pin_load (
   input  wire logic [7:0] port_pins_out, port_pins_oe, port_pullup_on,
   input  wire logic [7:0] ext, ext_en,
   output logic      [7:0] port_pins_in
);
   // Drive wins, then pull-up, then outside source; floating shows inverse
   always_comb
      for (int b = 0; b < 8; b++)
         port_pins_in[b] = port_pins_oe[b] ? port_pins_out[b] :
            port_pullup_on[b] ? 1'b1 : ext_en[b] ? ext[b] : ~ext[b];
endmodule

// >>> test_port0_gpio_realtime_output.sv
`timescale 1ns/100ps
module test_port0_gpio_realtime_output;
   import port0_pkg::*;
   logic mclk = 1'b0, sys_rst = 1'b1, latch_wr = 1'b0, latch_rd = 1'b0;
   logic dir_wr = 1'b0, rtctl_wr = 1'b0, rtctl_low_data = 1'b0;
   logic rtctl_high_data = 1'b0, rtbuf_low_wr = 1'b0, rtbuf_high_wr = 1'b0;
   logic pullup_wr = 1'b0, pullup_data = 1'b0;
   logic [7:0] latch_wr_data = 8'h00, dir_wr_data = 8'h00, ext = 8'h00;
   logic [7:0] ext_en = 8'h00, port_rd_data, port_direction_reg;
   logic [7:0] port_pins_in, port_pins_out, port_pins_oe, port_pullup_on;
   logic [3:0] rtbuf_low_data = 4'h0, rtbuf_high_data = 4'h0;
   logic [3:0] realtime_buffer_low, realtime_buffer_high, bl, bh;
   logic realtime_low_enable, realtime_high_enable, port_pullup_enable;
   logic le, he, pu;
   logic [7:0] dir, lat, rd, eoe;
   wire  [7:0] m = {{4{he}}, {4{le}}};
   logic [31:0] r1, r2, seed = 32'h3159;
   int failures = 0, cmp_count = 0;
   port0_gpio_realtime_output port0_gpio_realtime_output_inst (.*);
   pin_load pin_load_inst (.*);
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (sys_rst) begin
         {dir, lat, rd, le, he, pu, bl, bh} <= {DIR_RESET, 27'h0};
      end else begin
         if (latch_rd) rd <= (dir & ~m & port_pins_in) | (~(dir & ~m) & lat);
         if (latch_wr) lat <= (lat & m) | (latch_wr_data & ~m);
         if (dir_wr) dir <= dir_wr_data;
         if (rtctl_wr) {he, le} <= {rtctl_high_data, rtctl_low_data};
         if (rtbuf_low_wr) bl <= rtbuf_low_data;
         if (rtbuf_high_wr) bh <= rtbuf_high_data;
         if (pullup_wr) pu <= pullup_data;
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #75000 failures++;
      wrap_up();
   end
   initial begin
      repeat (16) @(posedge mclk);
      for (int i = 0; i < 2000; i++) begin
         #1 r1 = $random(seed);
         r2 = $random(seed);
         sys_rst = i >= 1000 && i < 1002;
         {ext_en, ext, dir_wr_data, latch_wr_data} = r1;
         {latch_wr, dir_wr, rtctl_wr} = {~|r2[1:0], ~|r2[3:2], ~|r2[5:4]};
         {rtbuf_low_wr, rtbuf_high_wr} = {~|r2[7:6], ~|r2[9:8]};
         {pullup_wr, latch_rd, pullup_data} = {~|r2[11:10], r2[12], r2[23]};
         {rtctl_high_data, rtctl_low_data} = r2[14:13];
         {rtbuf_high_data, rtbuf_low_data} = r2[22:15];
         // Every realtime mode, each followed by a latch write
         if (i < 8) {rtctl_wr, latch_wr, rtctl_high_data, rtctl_low_data} =
            {~i[0], i[0], i[2:1]};
         @(negedge mclk);
         eoe = ~dir | m;
         chk(port_pins_oe, eoe);
         chk(port_pins_out & eoe, ({bh, bl} & m | lat & ~m) & eoe);
         chk(port_pullup_on, {8{pu}} & dir & ~m);
         chk(port_rd_data, rd);
         chk(port_direction_reg, dir);
         chk({realtime_buffer_high, realtime_buffer_low}, {bh, bl});
         chk({6'h00, realtime_high_enable, realtime_low_enable},
             {6'h00, he, le});
         chk({7'h00, port_pullup_enable}, {7'h00, pu});
         @(posedge mclk);
      end
      wrap_up();
   end
endmodule
